// >>> tb/testbench.sv
// Purpose: Self-checking bench for the two-wire status/data path
// Assumes: QUARTER cut to 4 clocks; partner model on the far side
// Notes:   Reads queue expectations; a monitor compares them on ack
`timescale 1ns/1ps
`default_nettype none
module testbench
   import twb_pkg::*;
;
   logic        clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack_en = 1'b1;
   logic        ack, scl_oe, sda_oe, p_scl, p_sda, rx_stb, an;
   logic [7:0]  adr = 8'h00, rx_byte, pq;
   logic [3:0]  sel = 4'h1;
   logic [31:0] dat = 32'h0, dat_o, rq;
   logic [23:0] e;
   logic [23:0] exp_q[$];
   logic [7:0]  byte_q[$];
   int          mismatches = 0, checks_done = 0, seed = 32'h9521971b;
   wire logic   scl_ln = !(scl_oe | p_scl);
   wire logic   sda_ln = !(sda_oe | p_sda);

   always #25 clk = ~clk;

   two_wire_bus_status_data_path #(.QUARTER(4)) two_wire_bus_status_data_path_i (
      .clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .scl_i(scl_ln),
      .scl_o(), .scl_oe(scl_oe), .sda_i(sda_ln), .sda_o(), .sda_oe(sda_oe));
   twb_bus_partner twb_bus_partner_i (.scl(scl_ln), .sda(sda_ln), .scl_oe(p_scl), .sda_oe(p_sda),
      .ack_en(ack_en), .rx_byte(rx_byte), .rx_stb(rx_stb));

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      checks_done++;
      if (s !== x) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // One classic cycle; me is {mask, expected} for reads
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [15:0] me);
      logic [31:0] r;
      r = $random(seed);
      @(posedge clk);
      if (!w) exp_q.push_back({a, me});
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= {r[7:5], 1'b1};
      dat <= {r[31:8], d};
      do @(posedge clk); while (ack !== 1'b1);
      rq = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic poll(input logic [7:0] m, input logic [7:0] v);
      int n;
      n = 0;
      do begin
         bus(OFS_STAT, 1'b0, 8'h00, 16'h0);
         n++;
      end while ((rq[7:0] & m) !== v && n < 500);
      // A poll that runs out counts against the run
      if ((rq[7:0] & m) !== v) mismatches++;
   endtask

   always @(posedge clk) begin
      if (ack === 1'b1 && we === 1'b0) begin
         e = exp_q.pop_front();
         if (e[15:8] != 8'h00) chk($sformatf("reg %h", e[23:16]), dat_o & {24'h0, e[15:8]}, {24'h0, e[7:0]});
      end
   end
   always @(posedge rx_stb) chk("bus byte", {24'h0, rx_byte}, {24'h0, byte_q.pop_front()});

   initial begin
      #2_000_000;
      mismatches++;
      conclude();
   end

   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      bus(OFS_OWN, 0, 0, 16'hff00);
      bus(OFS_STAT, 0, 0, 16'hff00);
      bus(8'h14, 1, 8'ha5, 0);
      bus(8'h14, 0, 0, 16'hff00);
      bus(OFS_ACTL, 1, 8'hff, 0);
      bus(OFS_ACTL, 0, 0, 16'hffc7);
      bus(OFS_CTRL, 1, 8'hdf, 0);
      bus(OFS_CTRL, 0, 0, 16'hff18);
      bus(OFS_STAT, 1, 8'hff, 0);
      bus(OFS_STAT, 0, 0, 16'hff00);
      $display("test registers done");
      bus(OFS_ACTL, 1, 8'h00, 0);
      bus(OFS_OWN, 1, 8'h6a, 0);
      twb_bus_partner_i.stretch = 900;
      bus(OFS_CTRL, 1, 8'h30, 0);
      poll(8'h20, 8'h20);
      byte_q.push_back(8'ha4);
      bus(OFS_DATA, 1, 8'ha4, 0);
      poll(8'h80, 8'h80);
      bus(OFS_STAT, 0, 0, 16'hffa2);
      bus(OFS_STAT, 1, 8'h02, 0);
      bus(OFS_STAT, 0, 0, 16'h0200);
      twb_bus_partner_i.stretch = 0;
      ack_en = 1'b0;
      byte_q.push_back(8'h5b);
      bus(OFS_DATA, 1, 8'h5b, 0);
      bus(OFS_STAT, 0, 0, 16'h8000);
      poll(8'h80, 8'h80);
      bus(OFS_STAT, 0, 0, 16'h8383);
      bus(OFS_CTRL, 1, 8'h10, 0);
      poll(8'h20, 8'h00);
      bus(OFS_STAT, 0, 0, 16'h2000);
      $display("test master transmit done");
      ack_en = 1'b1;
      byte_q.push_back(8'hd3);
      byte_q.push_back(8'hff);
      bus(OFS_CTRL, 1, 8'h30, 0);
      poll(8'h20, 8'h20);
      bus(OFS_DATA, 1, 8'hd3, 0);
      poll(8'h80, 8'h80);
      bus(OFS_CTRL, 1, 8'h28, 0);
      bus(OFS_DATA, 0, 0, 16'h0);
      poll(8'h80, 8'h80);
      bus(OFS_CTRL, 1, 8'h18, 0);
      bus(OFS_DATA, 0, 0, 16'hffff);
      bus(OFS_STAT, 0, 0, 16'h8080);
      poll(8'h20, 8'h00);
      $display("test master receive done");
      twb_bus_partner_i.mstart();
      poll(8'h20, 8'h20);
      bus(OFS_CTRL, 1, 8'h30, 0);
      bus(OFS_STAT, 0, 0, 16'h1212);
      bus(OFS_CTRL, 0, 0, 16'h2000);
      bus(OFS_STAT, 1, 8'h00, 0);
      bus(OFS_STAT, 0, 0, 16'h1010);
      bus(OFS_STAT, 1, 8'h12, 0);
      bus(OFS_STAT, 0, 0, 16'h1200);
      twb_bus_partner_i.mbyte(8'h00, an, pq);
      chk("broadcast off ack", {31'h0, an}, 32'h1);
      bus(OFS_STAT, 0, 0, 16'h4000);
      twb_bus_partner_i.mstop();
      $display("test contention done");
      bus(OFS_ACTL, 1, 8'h80, 0);
      bus(OFS_CTRL, 1, 8'h00, 0);
      twb_bus_partner_i.mstart();
      twb_bus_partner_i.mbyte(8'h00, an, pq);
      chk("broadcast ack", {31'h0, an}, 32'h0);
      bus(OFS_STAT, 0, 0, 16'h6662);
      fork
         twb_bus_partner_i.mbyte(8'hc3, an, pq);
         begin
            bus(OFS_DATA, 0, 0, 16'h0);
            poll(8'h80, 8'h80);
            bus(OFS_DATA, 0, 0, 16'hffc3);
            bus(OFS_STAT, 0, 0, 16'h8000);
         end
      join
      chk("data ack", {31'h0, an}, 32'h0);
      twb_bus_partner_i.mstop();
      $display("test slave receive done");
      bus(OFS_ACTL, 1, 8'h00, 0);
      twb_bus_partner_i.mstart();
      twb_bus_partner_i.mbyte(8'h6b, an, pq);
      chk("own address ack", {31'h0, an}, 32'h0);
      bus(OFS_STAT, 0, 0, 16'h6464);
      bus(OFS_CTRL, 1, 8'h10, 0);
      bus(OFS_STAT, 0, 0, 16'h4000);
      fork
         twb_bus_partner_i.mbyte(8'hff, an, pq);
         bus(OFS_DATA, 1, 8'h96, 0);
      join
      chk("slave byte", {24'h0, pq}, 32'h96);
      bus(OFS_STAT, 0, 0, 16'h0101);
      twb_bus_partner_i.mstop();
      poll(8'h20, 8'h00);
      bus(OFS_STAT, 0, 0, 16'h2000);
      $display("test slave transmit done");
      conclude();
   end
endmodule
`default_nettype wire

// >>> tb/twb_assertions.sv
// Purpose: Port checker for the two-wire status/data path
// Assumes: Bound to the top module, one clock domain
// Notes:   Register bus answers one cycle after a taken request
`timescale 1ns/1ps
`default_nettype none
module twb_assertions
   import twb_pkg::*;
#(
   parameter int QUARTER = QUARTER_CYC
) (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rstn,
   // Register bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // Bus pins
   input wire logic        scl_i,
   input wire logic        scl_o,
   input wire logic        scl_oe,
   input wire logic        sda_i,
   input wire logic        sda_o,
   input wire logic        sda_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   wire logic rd = wb_ack_o && !wb_we_i;

   a_ack_taken: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
   a_read_holds: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("read data moved");
   a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
   a_stat_gap: assert property (rd && wb_adr_i == OFS_STAT |-> !wb_dat_o[3]) else $error("status gap");
   a_actl_gap: assert property (rd && wb_adr_i == OFS_ACTL |-> wb_dat_o[5:3] == 3'h0) else $error("actl gap");
   a_ctrl_gap: assert property (rd && wb_adr_i == OFS_CTRL |-> {wb_dat_o[7:6], wb_dat_o[2:0]} == 5'h0)
      else $error("ctrl gap");
   a_unmapped_zero: assert property (rd && wb_adr_i == 8'h14 |-> wb_dat_o == 32'h0) else $error("unmapped");
   a_open_drain: assert property (!scl_o && !sda_o) else $error("line driven high");

   c_start: cover property ($rose(sda_oe) && !scl_oe);
   c_slave_ack: cover property (sda_oe && !scl_oe && !scl_i);
   c_data_read: cover property (rd && wb_adr_i == OFS_DATA);
endmodule

bind two_wire_bus_status_data_path twb_assertions #(.QUARTER(QUARTER)) twb_assertions_i (
   .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe(sda_oe));
`default_nettype wire

// >>> tb/twb_bus_partner.sv
// Purpose: Far-side party: slave receiver and second master
// Assumes: Bench resolves lines as wired-AND with pull-ups
// Notes:   400 ns link clock, still between frames
`timescale 1ns/1ps
`default_nettype none
module twb_bus_partner (
   // Resolved lines
   input  wire logic       scl,
   input  wire logic       sda,
   // Pulls, high pulls the line low
   output var  logic       scl_oe,
   output var  logic       sda_oe,
   // Receiver side
   input  wire logic       ack_en,
   output var  logic [7:0] rx_byte,
   output var  logic       rx_stb
);
   logic [7:0] sh = 8'h00;
   logic       master_select = 1'b0;
   int         cnt = 10;
   int         stretch = 0;
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
      rx_byte = 8'h00;
      rx_stb = 1'b0;
   end
   always @(negedge sda) if (scl === 1'b1) cnt = 0;
   always @(posedge scl) if (cnt < 8) begin
      sh = {sh[6:0], sda};
      cnt = cnt + 1;
   end
   always @(negedge scl) begin
      if (cnt == 9) begin
         cnt = 0;
         #100 if (!master_select) sda_oe = 1'b0;
      end
      if (cnt == 8) begin
         cnt = 9;
         if (!master_select) begin
            rx_byte = sh;
            rx_stb = 1'b1;
            #100 sda_oe = ack_en;
            scl_oe = (stretch != 0);
            #(stretch) scl_oe = 1'b0;
            rx_stb = 1'b0;
         end
      end
   end
   // Data moves early in the low half; the long low time covers the
   // slave's synchroniser delay so its data never moves with the rise
   task automatic mbit(input logic b, output logic r);
      #50 sda_oe = !b;
      #200 scl_oe = 1'b0;
      wait (scl === 1'b1);
      #150 r = sda;
      scl_oe = 1'b1;
   endtask
   task automatic mbyte(input logic [7:0] d, output logic ack_n, output logic [7:0] q);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         mbit(d[i], r);
         q = {q[6:0], r};
      end
      mbit(1'b1, ack_n);
   endtask
   task automatic mstart;
      master_select = 1'b1;
      sda_oe = 1'b1;
      #200 scl_oe = 1'b1;
   endtask
   task automatic mstop;
      #100 sda_oe = 1'b1;
      #100 scl_oe = 1'b0;
      wait (scl === 1'b1);
      #200 sda_oe = 1'b0;
      #200 master_select = 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> verilog/twb_pkg.sv
// Purpose: Shared constants and types for the two-wire bus status/data path
// Assumes: 20 MHz system clock, 32-bit classic Wishbone register bus
// Notes:   Register offsets are byte addresses, one aligned word each
package twb_pkg;
   // Timing
   localparam int CLK_HZ      = 20_000_000;
   localparam int SCL_HZ      = 100_000;
   localparam int QUARTER_CYC = CLK_HZ / (4 * SCL_HZ);
   // Register byte offsets
   localparam logic [7:0] OFS_OWN  = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_DATA = 8'h0c;
   localparam logic [7:0] OFS_ACTL = 8'h10;
   // First control register fields
   localparam int CTRL_MST  = 5;
   localparam int CTRL_TX   = 4;
   localparam int CTRL_TXAK = 3;
   // Status fields
   localparam int ST_DONE = 7;
   localparam int ST_HIT  = 6;
   localparam int ST_BUSY = 5;
   localparam int ST_LOST = 4;
   localparam int ST_DIR  = 2;
   localparam int ST_IRQ  = 1;
   localparam int ST_ACKN = 0;
   // Addressing control fields
   localparam int ACTL_GC   = 7;
   localparam int ACTL_WIDE = 6;
   localparam int ACTL_HI   = 2;
   // Reset values
   localparam logic [7:0] OWN_RST  = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] ACTL_RST = 8'h00;
   // Wide address header prefix
   localparam logic [4:0] TEN_HDR = 5'h1e;

   typedef enum logic [2:0] {
      M_IDLE  = 3'b000,
      M_START = 3'b001,
      M_WAIT  = 3'b011,
      M_LOW   = 3'b010,
      M_HIGH  = 3'b110,
      M_STOP  = 3'b111
   } mst_state_t;

   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_ADDR  = 3'b001,
      S_ACK   = 3'b011,
      S_HOLD  = 3'b010,
      S_DATA  = 3'b110,
      S_DACK  = 3'b111,
      S_ADDR2 = 3'b101
   } slv_state_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } bus_pins_t;
endpackage

// >>> verilog/two_wire_bus_status_data_path.sv
// Purpose: Status flags, data port and addressing control of a two-wire bus controller
// Assumes: Open-drain pins resolved outside; pins pass a two-stage synchroniser
// Notes:   Master and slave bit engines share the pins; the master issues no repeated start
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module two_wire_bus_status_data_path
   import twb_pkg::*;
#(
   parameter int QUARTER = QUARTER_CYC
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   // Two-wire bus pins
   input  wire logic        scl_i,
   output var  logic        scl_o,
   output var  logic        scl_oe,
   input  wire logic        sda_i,
   output var  logic        sda_o,
   output var  logic        sda_oe
);

   bus_pins_t  pin_m_q, pin_s_q, pin_p_q;
   logic [7:0] own_q, ctrl_q, actl_q, rx_q;
   logic       done_q, hit_q, busy_q, lost_q, dir_q, irq_q, ackn_q;
   logic       acc, wr_ctrl, wr_stat, wr_data, rd_data, go;
   logic       start_det, stop_det, scl_rise, scl_fall;
   logic [7:0] rdata;
   logic [$clog2(QUARTER)-1:0] div_q;
   logic       tick;
   mst_state_t m_st_q;
   logic       m_scl_low_q, m_sda_low_q, m_ph_q, m_done, m_lost, m_ack_v;
   logic [3:0] m_cnt_q;
   logic [7:0] m_sh_q;
   slv_state_t s_st_q;
   logic       s_scl_low_q, s_sda_low_q, s_two_q, s_ten_q, s_done, s_hit, s_ack_v, s_rx_v;
   logic [3:0] s_cnt_q;
   logic [7:0] s_sh_q;
   logic       ms_prev_q;

   // Wishbone decode, one wait state per access
   assign acc     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_ctrl = acc & wb_we_i & wb_sel_i[0] & (wb_adr_i == OFS_CTRL);
   assign wr_stat = acc & wb_we_i & wb_sel_i[0] & (wb_adr_i == OFS_STAT);
   assign wr_data = acc & wb_we_i & wb_sel_i[0] & (wb_adr_i == OFS_DATA);
   assign rd_data = acc & ~wb_we_i & (wb_adr_i == OFS_DATA);
   assign go      = ctrl_q[CTRL_TX] ? wr_data : rd_data;

   always_comb begin
      rdata = 8'h00;
      if (wb_adr_i == OFS_OWN) begin
         rdata = own_q;
      end else if (wb_adr_i == OFS_CTRL) begin
         rdata = ctrl_q;
      end else if (wb_adr_i == OFS_STAT) begin
         rdata = {done_q, hit_q, busy_q, lost_q, 1'b0, dir_q, irq_q, ackn_q};
      end else if (wb_adr_i == OFS_DATA) begin
         rdata = rx_q;
      end else if (wb_adr_i == OFS_ACTL) begin
         rdata = actl_q;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= acc;
         if (acc) begin
            wb_dat_o <= {24'h00_0000, rdata};
         end
      end
   end

   // Writable configuration; hardware drops master select on contention loss
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         own_q  <= OWN_RST;
         ctrl_q <= CTRL_RST;
         actl_q <= ACTL_RST;
      end else begin
         if (acc && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_OWN) begin
            own_q <= wb_dat_i[7:0];
         end
         if (acc && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_ACTL) begin
            actl_q <= wb_dat_i[7:0] & 8'hc7;
         end
         if (wr_ctrl) begin
            ctrl_q <= wb_dat_i[7:0] & 8'h38;
         end
         if (m_lost) begin
            ctrl_q[CTRL_MST] <= 1'b0;
         end
      end
   end

   // Pin synchroniser; first stage feeds only the second
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin_m_q <= 2'b11;
         pin_s_q <= 2'b11;
         pin_p_q <= 2'b11;
      end else begin
         pin_m_q <= {scl_i, sda_i};
         pin_s_q <= pin_m_q;
         pin_p_q <= pin_s_q;
      end
   end

   assign start_det = pin_s_q.scl & pin_p_q.scl & pin_p_q.sda & ~pin_s_q.sda;
   assign stop_det  = pin_s_q.scl & pin_p_q.scl & ~pin_p_q.sda & pin_s_q.sda;
   assign scl_rise  = pin_s_q.scl & ~pin_p_q.scl;
   assign scl_fall  = ~pin_s_q.scl & pin_p_q.scl;

   // Quarter bit-period enable
   assign tick = (div_q == ($clog2(QUARTER))'(QUARTER - 1));
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         div_q <= '0;
      end else begin
         div_q <= tick ? '0 : div_q + 1'b1;
      end
   end

   // Status flags; a set in the same cycle as its clear wins
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         done_q <= 1'b0;
         hit_q  <= 1'b0;
         busy_q <= 1'b0;
         lost_q <= 1'b0;
         irq_q  <= 1'b0;
      end else begin
         if (m_done || s_done) begin
            done_q <= 1'b1;
         end else if ((rd_data && !ctrl_q[CTRL_TX]) || (wr_data && ctrl_q[CTRL_TX])) begin
            done_q <= 1'b0;
         end
         if (s_hit) begin
            hit_q <= 1'b1;
         end else if (wr_ctrl) begin
            hit_q <= 1'b0;
         end
         if (start_det) begin
            busy_q <= 1'b1;
         end else if (stop_det) begin
            busy_q <= 1'b0;
         end
         if (m_lost) begin
            lost_q <= 1'b1;
         end else if (wr_stat && wb_dat_i[ST_LOST]) begin
            lost_q <= 1'b0;
         end
         if (m_done || s_done || s_hit || m_lost) begin
            irq_q <= 1'b1;
         end else if (wr_stat && wb_dat_i[ST_IRQ]) begin
            irq_q <= 1'b0;
         end
      end
   end

   // Received byte, acknowledge record and slave direction
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_q   <= 8'h00;
         ackn_q <= 1'b0;
         dir_q  <= 1'b0;
      end else begin
         if (m_done && !ctrl_q[CTRL_TX]) begin
            rx_q <= m_sh_q;
         end else if (s_rx_v) begin
            rx_q <= s_sh_q;
         end
         if (m_ack_v || s_ack_v) begin
            ackn_q <= pin_s_q.sda;
         end
         if (s_hit) begin
            dir_q <= s_sh_q[0] & (s_sh_q != 8'h00);
         end
      end
   end

   // Master engine: drives the clock from the quarter enable, waits out stretching
   assign m_done  = (m_st_q == M_HIGH) && pin_s_q.scl && tick && m_ph_q && (m_cnt_q == 4'd8);
   assign m_ack_v = m_done && ctrl_q[CTRL_TX];
   assign m_lost  = ((m_st_q == M_IDLE) && ctrl_q[CTRL_MST] && !ms_prev_q && busy_q)
                 || ((m_st_q == M_HIGH) && pin_s_q.scl && tick && m_ph_q && ctrl_q[CTRL_TX]
                     && (m_cnt_q < 4'd8) && !m_sda_low_q && !pin_s_q.sda);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         m_st_q      <= M_IDLE;
         m_scl_low_q <= 1'b0;
         m_sda_low_q <= 1'b0;
         m_ph_q      <= 1'b0;
         m_cnt_q     <= 4'd0;
         m_sh_q      <= 8'h00;
         ms_prev_q   <= 1'b0;
      end else begin
         ms_prev_q <= ctrl_q[CTRL_MST];
         case (m_st_q)
            M_IDLE: begin
               m_scl_low_q <= 1'b0;
               m_sda_low_q <= 1'b0;
               if (ctrl_q[CTRL_MST] && !ms_prev_q && !busy_q) begin
                  m_sda_low_q <= 1'b1;
                  m_st_q      <= M_START;
               end
            end
            M_START: begin
               if (tick) begin
                  m_scl_low_q <= 1'b1;
                  m_st_q      <= M_WAIT;
               end
            end
            M_WAIT: begin
               m_ph_q <= 1'b0;
               if (!ctrl_q[CTRL_MST]) begin
                  m_sda_low_q <= 1'b1;
                  m_st_q      <= M_STOP;
               end else if (go) begin
                  m_sh_q  <= wb_dat_i[7:0];
                  m_cnt_q <= 4'd0;
                  m_st_q  <= M_LOW;
               end
            end
            M_LOW: begin
               if (tick && !m_ph_q) begin
                  m_ph_q <= 1'b1;
                  if (m_cnt_q == 4'd8) begin
                     m_sda_low_q <= !ctrl_q[CTRL_TX] && !ctrl_q[CTRL_TXAK];
                  end else begin
                     m_sda_low_q <= ctrl_q[CTRL_TX] && !m_sh_q[7];
                  end
               end else if (tick) begin
                  m_ph_q      <= 1'b0;
                  m_scl_low_q <= 1'b0;
                  m_st_q      <= M_HIGH;
               end
            end
            M_HIGH: begin
               // Clock high time counts only once the wired line is really high
               if (pin_s_q.scl && tick && !m_ph_q) begin
                  m_ph_q <= 1'b1;
               end else if (pin_s_q.scl && tick) begin
                  m_ph_q      <= 1'b0;
                  m_scl_low_q <= 1'b1;
                  m_cnt_q     <= m_cnt_q + 4'd1;
                  if (m_cnt_q < 4'd8) begin
                     m_sh_q <= {m_sh_q[6:0], pin_s_q.sda};
                  end
                  if (m_lost) begin
                     m_scl_low_q <= 1'b0;
                     m_sda_low_q <= 1'b0;
                     m_st_q      <= M_IDLE;
                  end else if (m_cnt_q == 4'd8) begin
                     m_st_q <= M_WAIT;
                  end else begin
                     m_st_q <= M_LOW;
                  end
               end
            end
            M_STOP: begin
               if (tick && !m_ph_q) begin
                  m_ph_q      <= 1'b1;
                  m_scl_low_q <= 1'b0;
               end else if (tick && pin_s_q.scl) begin
                  m_ph_q      <= 1'b0;
                  m_sda_low_q <= 1'b0;
                  m_st_q      <= M_IDLE;
               end
            end
            default: begin
               m_st_q <= M_IDLE;
            end
         endcase
      end
   end

   // Slave engine: follows the bus clock edges, stretches the clock between bytes
   logic       seven_hit, ten_hdr, gc_hit;
   assign gc_hit    = (s_sh_q == 8'h00) && actl_q[ACTL_GC];
   assign seven_hit = !actl_q[ACTL_WIDE] && (s_sh_q[7:1] == own_q[7:1]);
   assign ten_hdr   = actl_q[ACTL_WIDE] && (s_sh_q[7:1] == {TEN_HDR, actl_q[1:0]});
   assign s_hit     = !ctrl_q[CTRL_MST] && scl_fall && (s_cnt_q == 4'd8)
                   && (((s_st_q == S_ADDR) && (gc_hit || seven_hit || (ten_hdr && s_sh_q[0] && s_ten_q)))
                       || ((s_st_q == S_ADDR2) && (s_sh_q == own_q)));
   assign s_done    = (s_st_q == S_DACK) && scl_fall;
   assign s_ack_v   = (s_st_q == S_DACK) && scl_rise && dir_q;
   assign s_rx_v    = (s_st_q == S_DATA) && scl_fall && (s_cnt_q == 4'd8) && !dir_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_st_q      <= S_IDLE;
         s_scl_low_q <= 1'b0;
         s_sda_low_q <= 1'b0;
         s_two_q     <= 1'b0;
         s_ten_q     <= 1'b0;
         s_cnt_q     <= 4'd0;
         s_sh_q      <= 8'h00;
      end else if (stop_det) begin
         s_st_q      <= S_IDLE;
         s_scl_low_q <= 1'b0;
         s_sda_low_q <= 1'b0;
         s_ten_q     <= 1'b0;
      end else if (start_det) begin
         s_st_q      <= S_ADDR;
         s_scl_low_q <= 1'b0;
         s_sda_low_q <= 1'b0;
         s_cnt_q     <= 4'd0;
      end else begin
         case (s_st_q)
            S_ADDR, S_ADDR2: begin
               if (scl_rise && s_cnt_q < 4'd8) begin
                  s_sh_q  <= {s_sh_q[6:0], pin_s_q.sda};
                  s_cnt_q <= s_cnt_q + 4'd1;
               end else if (scl_fall && s_cnt_q == 4'd8) begin
                  s_two_q <= 1'b0;
                  if (s_hit) begin
                     s_sda_low_q <= 1'b1;
                     s_ten_q     <= s_ten_q | (s_st_q == S_ADDR2);
                     s_st_q      <= S_ACK;
                  end else if (s_st_q == S_ADDR && ten_hdr && !s_sh_q[0] && !ctrl_q[CTRL_MST]) begin
                     s_sda_low_q <= 1'b1;
                     s_two_q     <= 1'b1;
                     s_st_q      <= S_ACK;
                  end else begin
                     s_st_q <= S_IDLE;
                  end
               end
            end
            S_ACK: begin
               if (scl_fall) begin
                  s_sda_low_q <= 1'b0;
                  s_cnt_q     <= 4'd0;
                  if (s_two_q) begin
                     s_st_q <= S_ADDR2;
                  end else begin
                     s_scl_low_q <= 1'b1;
                     s_st_q      <= S_HOLD;
                  end
               end
            end
            S_HOLD: begin
               // Clock held low until software moves the next byte
               if (go) begin
                  s_scl_low_q <= 1'b0;
                  s_cnt_q     <= 4'd0;
                  s_sh_q      <= wb_dat_i[7:0];
                  s_sda_low_q <= ctrl_q[CTRL_TX] && !wb_dat_i[7];
                  s_st_q      <= S_DATA;
               end
            end
            S_DATA: begin
               if (scl_rise && s_cnt_q < 4'd8) begin
                  s_cnt_q <= s_cnt_q + 4'd1;
                  if (!dir_q) begin
                     s_sh_q <= {s_sh_q[6:0], pin_s_q.sda};
                  end
               end else if (scl_fall && s_cnt_q == 4'd8) begin
                  s_sda_low_q <= !dir_q && !ctrl_q[CTRL_TXAK];
                  s_st_q      <= S_DACK;
               end else if (scl_fall && dir_q) begin
                  s_sda_low_q <= !s_sh_q[6];
                  s_sh_q      <= {s_sh_q[6:0], 1'b0};
               end
            end
            S_DACK: begin
               if (scl_rise) begin
                  s_two_q <= pin_s_q.sda;
               end else if (scl_fall) begin
                  s_sda_low_q <= 1'b0;
                  if (dir_q && s_two_q) begin
                     s_st_q <= S_IDLE;
                  end else begin
                     s_scl_low_q <= 1'b1;
                     s_st_q      <= S_HOLD;
                  end
               end
            end
            default: begin
               s_st_q <= S_IDLE;
            end
         endcase
      end
   end

   // Registered open-drain pin stage
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scl_o  <= 1'b0;
         sda_o  <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         scl_o  <= 1'b0;
         sda_o  <= 1'b0;
         scl_oe <= m_scl_low_q | s_scl_low_q;
         sda_oe <= m_sda_low_q | s_sda_low_q;
      end
   end

endmodule

`default_nettype wire
